// ==== core/pfs_consts.svh ====
// constants for the port b/c/d pin function selector
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// register word index, byte address is index times four
`define PFS_IDX_PBL 3'h0
`define PFS_IDX_PBH 3'h1
`define PFS_IDX_PCL 3'h2
`define PFS_IDX_PCH 3'h3
`define PFS_IDX_PD 3'h4
`define PFS_IDX_SRC 3'h5
`define PFS_IDX_STS 3'h6
`define PFS_IDX_LSB 2
`define PFS_IDX_MSB 4
`define PFS_HIT_LSB 5

// reset values and implemented bits
`define PFS_RST_SEL 8'h00
`define PFS_RST_HI 6'h00
`define PFS_RST_SRC 1'b0
`define PFS_HI_W 6
`define PFS_SRC_EXTERNAL_INTERRUPT_ONE_BIT 0

// two-bit field numbers and select codes
`define PFS_F0 0
`define PFS_F1 1
`define PFS_F2 2
`define PFS_F3 3
`define PFS_SEL0 2'b00
`define PFS_SEL1 2'b01
`define PFS_SEL2 2'b10
`define PFS_SEL3 2'b11

// pin numbering: port b, then c, then d
`define PFS_NPIN 18
`define PFS_PB 0
`define PFS_PC 7
`define PFS_PD 14

// bus codes
`define PFS_HTRANS_NONSEQ 2'b10
`define PFS_WORD_ZERO 32'h0000_0000

`endif

// ==== core/pfs_pkg.sv ====
// types shared by the pin function selector
package pfs_pkg;

  // function that a pin currently carries
  typedef enum logic [3:0] {
    PFS_FN_GPIO, PFS_FN_CTMR, PFS_FN_STMR, PFS_FN_PTMR, PFS_FN_TX,
    PFS_FN_RX, PFS_FN_SCK, PFS_FN_CSEL, PFS_FN_SOUT, PFS_FN_SIN,
    PFS_FN_CKOUT, PFS_FN_LCD, PFS_FN_ANA, PFS_FN_XTAL, PFS_FN_OSC,
    PFS_FN_CMP
  } pfs_fn_t;

  // peripheral drive toward the pins
  typedef struct packed {
    logic compact_timer_output;
    logic standard_timer_output;
    logic periodic_timer_output;
    logic uart_tx;
    logic clock_output_pin;
    logic serial_data_out_line;
    logic sck_o;
    logic sck_oe;
    logic csel_o;
    logic csel_oe;
    logic sda_o;
    logic sda_oe;
  } pfs_periph_out_t;

  // pin levels handed to the peripherals
  typedef struct packed {
    logic external_interrupt_zero;
    logic external_interrupt_one;
    logic standard_timer_clock_input;
    logic uart_rx;
    logic serial_data_in_line;
    logic sck_i;
    logic serial_chip_select;
  } pfs_periph_in_t;

endpackage

// ==== core/pfs_ahb_if.sv ====
// ahb-lite address decode and data-phase tracking
`timescale 1ns/1ns
`include "pfs_consts.svh"

module pfs_ahb_if import pfs_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic wr_stb,
  output logic [2:0] wr_idx,
  output logic rd_now,
  output logic [2:0] rd_idx
);

  logic take;
  logic hit;
  logic wr_stb_reg;
  logic [2:0] wr_idx_reg;

  // a transfer is taken on nonseq with the bus ready
  assign take = hsel && hready && (htrans == `PFS_HTRANS_NONSEQ);
  assign hit = (haddr[31:`PFS_HIT_LSB] == '0) && (haddr[1:0] == 2'b00);
  assign rd_idx = haddr[`PFS_IDX_MSB:`PFS_IDX_LSB];
  assign rd_now = take && !hwrite && hit;
  assign wr_stb = wr_stb_reg;
  assign wr_idx = wr_idx_reg;

  // write is held over into its data phase, where hwdata stands
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_stb_reg <= 1'b0;
      wr_idx_reg <= `PFS_IDX_PBL;
    end else begin
      wr_stb_reg <= take && hwrite && hit;
      wr_idx_reg <= rd_idx;
    end
  end

endmodule // pfs_ahb_if

// ==== core/pfs_top.sv ====
// pin function selector for ports b, c and d with ahb-lite registers
// Behaviour
// - b low bits 7:6 route b3: gpio, compact timer, lcd 11, analog 7
// - b low bits 5:4 route b2: gpio/timer clock, timer out, lcd, analog 2
// - b low bits 3:2 route b1: gpio/external_interrupt_one, lcd 9, analog 1, crystal 2
// - b low bits 1:0 route b0: gpio/external_interrupt_zero, lcd 8, analog 0, crystal 1
// - b high bits 5:4 route b6: gpio, serial clock, comparator +, lcd 14
// - b high bits 3:2 route b5: gpio, chip select, comparator -, lcd 13
// - b high bits 1:0 route b4: gpio, clock output, lcd 12, analog 8
// - b high bits 7:6 are absent and always read zero
// - c low bits 7:6 route c3: gpio twice, serial data out, lcd 18
// - c low bits 5:4 route c2: gpio twice, serial data out, lcd 17
// - c low bits 3:2 route c1: gpio, uart rx, lcd 16, oscillator 2
// - c low bits 1:0 route c0: gpio, uart tx, lcd 15, oscillator 1
// - c high bits 5:4 route c6: gpio twice, chip select, lcd 21
// - d bits 5:4 route d2: gpio, uart tx, lcd segment 24, analog 10
// - d bits 3:2 route d1: gpio, uart rx, lcd segment 23, analog 11
// - d bits 1:0 route d0: gpio twice, periodic timer, lcd 22
// - interrupt one comes from b1 when source bit clear, a2 when set
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "pfs_consts.svh"

module pfs_top import pfs_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [`PFS_NPIN-1:0] pin_in,
  input wire logic pin_a2_in,
  input wire logic [`PFS_NPIN-1:0] gpio_out,
  input wire logic [`PFS_NPIN-1:0] gpio_oe,
  input wire pfs_periph_out_t per_out,
  output pfs_periph_in_t per_in,
  output logic [`PFS_NPIN-1:0] pin_out,
  output logic [`PFS_NPIN-1:0] pin_oe,
  output logic [`PFS_NPIN-1:0] lcd_en,
  output logic [`PFS_NPIN-1:0] ana_en,
  output logic [`PFS_NPIN-1:0] xtal_en,
  output logic [`PFS_NPIN-1:0] osc_en,
  output logic [`PFS_NPIN-1:0] cmp_en
);

  // pick field k of a select register
  function automatic logic [1:0] fld(input logic [7:0] r, input int k);
    fld = r[2*k +: 2];
  endfunction

  // map a field code onto the four functions of a pin
  function automatic pfs_fn_t dec(input logic [1:0] f, input pfs_fn_t a,
                                  input pfs_fn_t b, input pfs_fn_t c,
                                  input pfs_fn_t d);
    unique case (f)
      `PFS_SEL0: dec = a;
      `PFS_SEL1: dec = b;
      `PFS_SEL2: dec = c;
      `PFS_SEL3: dec = d;
    endcase
  endfunction

  // value and enable that a function puts on its pin
  function automatic logic [1:0] drv(input pfs_fn_t f, input logic go,
                                     input logic goe,
                                     input pfs_periph_out_t p);
    unique case (f)
      PFS_FN_GPIO: drv = {go, goe};
      PFS_FN_CTMR: drv = {p.compact_timer_output, 1'b1};
      PFS_FN_STMR: drv = {p.standard_timer_output, 1'b1};
      PFS_FN_PTMR: drv = {p.periodic_timer_output, 1'b1};
      PFS_FN_TX: drv = {p.uart_tx, 1'b1};
      PFS_FN_CKOUT: drv = {p.clock_output_pin, 1'b1};
      PFS_FN_SOUT: drv = {p.serial_data_out_line, 1'b1};
      PFS_FN_SCK: drv = {p.sck_o, p.sck_oe};
      PFS_FN_CSEL: drv = {p.csel_o, p.csel_oe};
      PFS_FN_SIN: drv = {p.sda_o, p.sda_oe};
      PFS_FN_RX, PFS_FN_LCD, PFS_FN_ANA, PFS_FN_XTAL, PFS_FN_OSC,
      PFS_FN_CMP: drv = 2'b00;
    endcase
  endfunction

  logic wr_stb;
  logic [2:0] wr_idx;
  logic rd_now;
  logic [2:0] rd_idx;
  logic [7:0] pbl_reg, pcl_reg, pd_reg;
  logic [`PFS_HI_W-1:0] pbh_reg, pch_reg;
  logic src_reg;
  logic [7:0] pbl_next, pcl_next, pd_next, pbh_v, pch_v;
  logic [`PFS_HI_W-1:0] pbh_next, pch_next;
  logic src_next;
  logic [31:0] rd_val;
  logic [31:0] hrdata_reg;
  pfs_fn_t fn [`PFS_NPIN];
  logic [`PFS_NPIN-1:0] out_next, oe_next;
  logic [`PFS_NPIN-1:0] lcd_next, ana_next, xtal_next, osc_next, cmp_next;
  logic [`PFS_NPIN-1:0] out_reg, oe_reg;
  logic [`PFS_NPIN-1:0] lcd_reg, ana_reg, xtal_reg, osc_reg, cmp_reg;
  pfs_periph_in_t in_next, in_reg;

  pfs_ahb_if u_bus (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx),
    .rd_now(rd_now),
    .rd_idx(rd_idx)
  );

  // next register values; a write in its data phase is forwarded
  assign pbl_next = (wr_stb && wr_idx == `PFS_IDX_PBL) ?
                    hwdata[7:0] : pbl_reg;
  assign pbh_next = (wr_stb && wr_idx == `PFS_IDX_PBH) ?
                    hwdata[`PFS_HI_W-1:0] : pbh_reg;
  assign pcl_next = (wr_stb && wr_idx == `PFS_IDX_PCL) ?
                    hwdata[7:0] : pcl_reg;
  assign pch_next = (wr_stb && wr_idx == `PFS_IDX_PCH) ?
                    hwdata[`PFS_HI_W-1:0] : pch_reg;
  assign pd_next = (wr_stb && wr_idx == `PFS_IDX_PD) ?
                   hwdata[7:0] : pd_reg;
  assign src_next = (wr_stb && wr_idx == `PFS_IDX_SRC) ?
                    hwdata[`PFS_SRC_EXTERNAL_INTERRUPT_ONE_BIT] : src_reg;

  // high registers widened with their absent top bits as zero
  assign pbh_v = {2'b00, pbh_reg};
  assign pch_v = {2'b00, pch_reg};

  // read mux; unmapped words read as zero
  assign rd_val =
    (rd_idx == `PFS_IDX_PBL) ? {24'h00_0000, pbl_next} :
    (rd_idx == `PFS_IDX_PBH) ? {26'h000_0000, pbh_next} :
    (rd_idx == `PFS_IDX_PCL) ? {24'h00_0000, pcl_next} :
    (rd_idx == `PFS_IDX_PCH) ? {26'h000_0000, pch_next} :
    (rd_idx == `PFS_IDX_PD) ? {24'h00_0000, pd_next} :
    (rd_idx == `PFS_IDX_SRC) ? {31'h0000_0000, src_next} :
    (rd_idx == `PFS_IDX_STS) ? {14'h0000, pin_in} :
    `PFS_WORD_ZERO;

  // select registers and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      pbl_reg <= `PFS_RST_SEL;
      pbh_reg <= `PFS_RST_HI;
      pcl_reg <= `PFS_RST_SEL;
      pch_reg <= `PFS_RST_HI;
      pd_reg <= `PFS_RST_SEL;
      src_reg <= `PFS_RST_SRC;
      hrdata_reg <= `PFS_WORD_ZERO;
    end else begin
      pbl_reg <= pbl_next;
      pbh_reg <= pbh_next;
      pcl_reg <= pcl_next;
      pch_reg <= pch_next;
      pd_reg <= pd_next;
      src_reg <= src_next;
      hrdata_reg <= rd_now ? rd_val : `PFS_WORD_ZERO;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // port b pin functions
  assign fn[`PFS_PB+0] = dec(fld(pbl_reg, `PFS_F0), PFS_FN_GPIO,
    PFS_FN_LCD, PFS_FN_ANA, PFS_FN_XTAL);
  assign fn[`PFS_PB+1] = dec(fld(pbl_reg, `PFS_F1), PFS_FN_GPIO,
    PFS_FN_LCD, PFS_FN_ANA, PFS_FN_XTAL);
  assign fn[`PFS_PB+2] = dec(fld(pbl_reg, `PFS_F2), PFS_FN_GPIO,
    PFS_FN_STMR, PFS_FN_LCD, PFS_FN_ANA);
  assign fn[`PFS_PB+3] = dec(fld(pbl_reg, `PFS_F3), PFS_FN_GPIO,
    PFS_FN_CTMR, PFS_FN_LCD, PFS_FN_ANA);
  assign fn[`PFS_PB+4] = dec(fld(pbh_v, `PFS_F0), PFS_FN_GPIO,
    PFS_FN_CKOUT, PFS_FN_LCD, PFS_FN_ANA);
  assign fn[`PFS_PB+5] = dec(fld(pbh_v, `PFS_F1), PFS_FN_GPIO,
    PFS_FN_CSEL, PFS_FN_CMP, PFS_FN_LCD);
  assign fn[`PFS_PB+6] = dec(fld(pbh_v, `PFS_F2), PFS_FN_GPIO,
    PFS_FN_SCK, PFS_FN_CMP, PFS_FN_LCD);

  // port c pin functions
  assign fn[`PFS_PC+0] = dec(fld(pcl_reg, `PFS_F0), PFS_FN_GPIO,
    PFS_FN_TX, PFS_FN_LCD, PFS_FN_OSC);
  assign fn[`PFS_PC+1] = dec(fld(pcl_reg, `PFS_F1), PFS_FN_GPIO,
    PFS_FN_RX, PFS_FN_LCD, PFS_FN_OSC);
  assign fn[`PFS_PC+2] = dec(fld(pcl_reg, `PFS_F2), PFS_FN_GPIO,
    PFS_FN_GPIO, PFS_FN_SOUT, PFS_FN_LCD);
  assign fn[`PFS_PC+3] = dec(fld(pcl_reg, `PFS_F3), PFS_FN_GPIO,
    PFS_FN_GPIO, PFS_FN_SOUT, PFS_FN_LCD);
  assign fn[`PFS_PC+4] = dec(fld(pch_v, `PFS_F0), PFS_FN_GPIO,
    PFS_FN_GPIO, PFS_FN_SIN, PFS_FN_LCD);
  assign fn[`PFS_PC+5] = dec(fld(pch_v, `PFS_F1), PFS_FN_GPIO,
    PFS_FN_GPIO, PFS_FN_SCK, PFS_FN_LCD);
  assign fn[`PFS_PC+6] = dec(fld(pch_v, `PFS_F2), PFS_FN_GPIO,
    PFS_FN_GPIO, PFS_FN_CSEL, PFS_FN_LCD);

  // port d pin functions
  assign fn[`PFS_PD+0] = dec(fld(pd_reg, `PFS_F0), PFS_FN_GPIO,
    PFS_FN_GPIO, PFS_FN_PTMR, PFS_FN_LCD);
  assign fn[`PFS_PD+1] = dec(fld(pd_reg, `PFS_F1), PFS_FN_GPIO,
    PFS_FN_RX, PFS_FN_LCD, PFS_FN_ANA);
  assign fn[`PFS_PD+2] = dec(fld(pd_reg, `PFS_F2), PFS_FN_GPIO,
    PFS_FN_TX, PFS_FN_LCD, PFS_FN_ANA);
  assign fn[`PFS_PD+3] = dec(fld(pd_reg, `PFS_F3), PFS_FN_GPIO,
    PFS_FN_CTMR, PFS_FN_LCD, PFS_FN_ANA);

  // per-pin drive and analog-side enables
  for (genvar i = 0; i < `PFS_NPIN; i++) begin : g_pin
    assign {out_next[i], oe_next[i]} =
      drv(fn[i], gpio_out[i], gpio_oe[i], per_out);
    assign lcd_next[i] = (fn[i] == PFS_FN_LCD);
    assign ana_next[i] = (fn[i] == PFS_FN_ANA);
    assign xtal_next[i] = (fn[i] == PFS_FN_XTAL);
    assign osc_next[i] = (fn[i] == PFS_FN_OSC);
    assign cmp_next[i] = (fn[i] == PFS_FN_CMP);
  end

  // input routing; gpio-shared inputs rely on the pin being an input
  assign in_next.external_interrupt_zero =
    (fn[`PFS_PB+0] == PFS_FN_GPIO) && pin_in[`PFS_PB+0];
  assign in_next.external_interrupt_one = src_reg ? pin_a2_in :
    ((fn[`PFS_PB+1] == PFS_FN_GPIO) && pin_in[`PFS_PB+1]);
  assign in_next.standard_timer_clock_input =
    (fn[`PFS_PB+2] == PFS_FN_GPIO) && pin_in[`PFS_PB+2];
  // receive idles high when no pin carries it; c1 takes priority
  assign in_next.uart_rx =
    (fn[`PFS_PC+1] == PFS_FN_RX) ? pin_in[`PFS_PC+1] :
    (fn[`PFS_PD+1] == PFS_FN_RX) ? pin_in[`PFS_PD+1] : 1'b1;
  assign in_next.serial_data_in_line =
    (fn[`PFS_PC+4] == PFS_FN_SIN) && pin_in[`PFS_PC+4];
  assign in_next.sck_i =
    (fn[`PFS_PB+6] == PFS_FN_SCK) ? pin_in[`PFS_PB+6] :
    (fn[`PFS_PC+5] == PFS_FN_SCK) && pin_in[`PFS_PC+5];
  // chip select is active low and idles high
  assign in_next.serial_chip_select =
    (fn[`PFS_PB+5] == PFS_FN_CSEL) ? pin_in[`PFS_PB+5] :
    (fn[`PFS_PC+6] == PFS_FN_CSEL) ? pin_in[`PFS_PC+6] : 1'b1;

  // pin-side output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= '0;
      oe_reg <= '0;
      lcd_reg <= '0;
      ana_reg <= '0;
      xtal_reg <= '0;
      osc_reg <= '0;
      cmp_reg <= '0;
      in_reg <= '0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      lcd_reg <= lcd_next;
      ana_reg <= ana_next;
      xtal_reg <= xtal_next;
      osc_reg <= osc_next;
      cmp_reg <= cmp_next;
      in_reg <= in_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = oe_reg;
  assign lcd_en = lcd_reg;
  assign ana_en = ana_reg;
  assign xtal_en = xtal_reg;
  assign osc_en = osc_reg;
  assign cmp_en = cmp_reg;
  assign per_in = in_reg;

  // routing checks, one cycle from field to pin side
  chk_b3_lcd_route: assert property (@(posedge clk) disable iff (rst)
    pbl_reg[7:6] == `PFS_SEL2 |=> lcd_en[`PFS_PB+3] && !pin_oe[`PFS_PB+3])
    else $error("b3 not on lcd line");

  chk_b2_timer_out: assert property (@(posedge clk) disable iff (rst)
    pbl_reg[5:4] == `PFS_SEL1 |=> pin_oe[`PFS_PB+2] &&
      pin_out[`PFS_PB+2] == $past(per_out.standard_timer_output))
    else $error("b2 not driven by timer");

  chk_b1_crystal_pin: assert property (@(posedge clk) disable iff (rst)
    pbl_reg[3:2] == `PFS_SEL3 |=> xtal_en[`PFS_PB+1] && !pin_oe[`PFS_PB+1]
      && (!per_in.external_interrupt_one || $past(src_reg)))
    else $error("b1 crystal routing wrong");

  chk_b0_int_route: assert property (@(posedge clk) disable iff (rst)
    pbl_reg[1:0] == `PFS_SEL0 |=>
      per_in.external_interrupt_zero == $past(pin_in[`PFS_PB+0]))
    else $error("b0 interrupt not routed");

  chk_b6_cmp_route: assert property (@(posedge clk) disable iff (rst)
    pbh_reg[5:4] == `PFS_SEL2 |=> cmp_en[`PFS_PB+6] && !lcd_en[`PFS_PB+6])
    else $error("b6 comparator routing wrong");

  chk_hi_read_zero: assert property (@(posedge clk) disable iff (rst)
    rd_now && rd_idx == `PFS_IDX_PBH |=> hrdata[31:`PFS_HI_W] == '0)
    else $error("absent high bits read nonzero");

  chk_c1_uart_rx: assert property (@(posedge clk) disable iff (rst)
    pcl_reg[3:2] == `PFS_SEL1 |=>
      per_in.uart_rx == $past(pin_in[`PFS_PC+1]) && !pin_oe[`PFS_PC+1])
    else $error("c1 receive not routed");

  chk_c0_uart_tx: assert property (@(posedge clk) disable iff (rst)
    pcl_reg[1:0] == `PFS_SEL1 |=> pin_oe[`PFS_PC+0] &&
      pin_out[`PFS_PC+0] == $past(per_out.uart_tx))
    else $error("c0 transmit not driven");

  chk_d0_timer_out: assert property (@(posedge clk) disable iff (rst)
    pd_reg[1:0] == `PFS_SEL2 |=> pin_oe[`PFS_PD+0] &&
      pin_out[`PFS_PD+0] == $past(per_out.periodic_timer_output))
    else $error("d0 periodic timer not driven");

  chk_d3_analog_pin: assert property (@(posedge clk) disable iff (rst)
    pd_reg[7:6] == `PFS_SEL3 |=> ana_en[`PFS_PD+3] && !pin_oe[`PFS_PD+3])
    else $error("d3 analog routing wrong");

  chk_external_interrupt_one_source: assert property (@(posedge clk) disable iff (rst)
    src_reg |=> per_in.external_interrupt_one == $past(pin_a2_in))
    else $error("interrupt one not from a2");

  chk_d_write_seen: assert property (@(posedge clk) disable iff (rst)
    wr_stb && wr_idx == `PFS_IDX_PD |=> pd_reg == $past(hwdata[7:0]))
    else $error("port d select write lost");

  chk_b4_clock_out: assert property (@(posedge clk) disable iff (rst)
    pbh_reg[1:0] == `PFS_SEL1 |=> pin_oe[`PFS_PB+4] &&
      pin_out[`PFS_PB+4] == $past(per_out.clock_output_pin))
    else $error("b4 clock output not driven");

  chk_c6_csel_in: assert property (@(posedge clk) disable iff (rst)
    pch_reg[5:4] == `PFS_SEL2 && pbh_reg[3:2] != `PFS_SEL1 |=>
      per_in.serial_chip_select == $past(pin_in[`PFS_PC+6]))
    else $error("c6 chip select not routed");

endmodule // pfs_top

// ==== tb/pfs_pad_model.sv ====
// pad model: pins driven by the selector or held by the board
`timescale 1ns/1ns
`include "pfs_consts.svh"

module pfs_pad_model (
  input wire logic [`PFS_NPIN-1:0] pin_out,
  input wire logic [`PFS_NPIN-1:0] pin_oe,
  input wire logic [`PFS_NPIN-1:0] ext_lvl,
  output logic [`PFS_NPIN-1:0] pin_in
);
  // a driven pad reads its own drive, a released pad the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // pfs_pad_model

// ==== tb/testbench.sv ====
// self-checking bench for the port b/c/d pin function selector
`timescale 1ns/1ns
`include "pfs_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end

module testbench import pfs_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, pin_a2_in;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [`PFS_NPIN-1:0] pin_in, gpio_out, gpio_oe, ext_lvl, pin_out, pin_oe;
  logic [`PFS_NPIN-1:0] lcd_en, ana_en, xtal_en, osc_en, cmp_en;
  pfs_periph_out_t per_out;
  pfs_periph_in_t per_in;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // function per pin and code: b0..b6, c0..c6, d0..d3
  localparam string KIND = {"GLAXGLAXGSLAGTLAGKLAGsCLGkCLGULOGRLO",
    "GGDLGGDLGGdLGGkLGGsLGGPLGRLAGULAGTLA"};

  always #5 clk = ~clk;

  pfs_top dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_in(pin_in), .pin_a2_in(pin_a2_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .per_out(per_out), .per_in(per_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .lcd_en(lcd_en), .ana_en(ana_en),
    .xtal_en(xtal_en), .osc_en(osc_en), .cmp_en(cmp_en));

  pfs_pad_model pad_u (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  // verdict and end of run
  task test_done;
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      test_done();
    end
  end

  // one single-word transfer, entered just after a rising edge
  task automatic ahb_xfer(input logic wr, input logic [31:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `PFS_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb_xfer(1'b1, a, d, r);
  endtask

  task automatic reg_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb_xfer(1'b0, a, `PFS_WORD_ZERO, r);
    `CHK(r, e)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
  endtask

  // everything clear after reset, all pins plain gpio
  task test_reset;
    for (int i = 0; i < 6; i++) begin
      reg_chk(32'(i) << 2, `PFS_WORD_ZERO);
    end
    `CHK(pin_oe, gpio_oe)
    `CHK(pin_out, gpio_out)
    `CHK(lcd_en | ana_en | xtal_en | osc_en | cmp_en, 18'h0_0000)
  endtask

  // absent bits, full-width fields and an unmapped word
  task test_regs;
    reg_wr(32'h0000_0004, 32'hffff_ffff);
    reg_chk(32'h0000_0004, 32'h0000_003f);
    reg_wr(32'h0000_000c, 32'hffff_ffff);
    reg_chk(32'h0000_000c, 32'h0000_003f);
    reg_wr(32'h0000_0010, 32'hffff_ffff);
    reg_chk(32'h0000_0010, 32'h0000_00ff);
    reg_wr(32'h0000_001c, 32'hffff_ffff);
    reg_chk(32'h0000_001c, `PFS_WORD_ZERO);
    for (int i = 0; i < 5; i++) begin
      reg_wr(32'(i) << 2, `PFS_WORD_ZERO);
    end
  endtask

  // every code of every pin field, one field away from gpio at a time
  task automatic test_routes(input pfs_periph_out_t po,
      input logic [`PFS_NPIN-1:0] ext);
    int r, f;
    byte k;
    logic eo, eq, lvl;
    logic [31:0] a, v;
    per_out <= po;
    ext_lvl <= ext;
    for (int p = 0; p < `PFS_NPIN; p++) begin
      for (int c = 0; c < 4; c++) begin
        r = (p < 4) ? 0 : (p < 7) ? 1 : (p < 11) ? 2 : (p < 14) ? 3 : 4;
        f = p - ((r == 0) ? 0 : (r == 1) ? 4 : (r == 2) ? 7 :
          (r == 3) ? 11 : 14);
        a = 32'(r) << 2;
        v = 32'(c) << (2 * f);
        k = KIND[p * 4 + c];
        reg_wr(a, v);
        reg_chk(a, v);
        repeat (3) @(posedge clk);
        eo = 1'b1;
        case (k)
          "G": begin
            eo = gpio_oe[p];
            eq = gpio_out[p];
          end
          "T": eq = po.compact_timer_output;
          "S": eq = po.standard_timer_output;
          "P": eq = po.periodic_timer_output;
          "U": eq = po.uart_tx;
          "K": eq = po.clock_output_pin;
          "D": eq = po.serial_data_out_line;
          "k": begin
            eo = po.sck_oe;
            eq = po.sck_o;
          end
          "s": begin
            eo = po.csel_oe;
            eq = po.csel_o;
          end
          "d": begin
            eo = po.sda_oe;
            eq = po.sda_o;
          end
          default: eo = 1'b0;
        endcase
        lvl = eo ? eq : ext[p];
        `CHK(pin_oe[p], eo)
        if (eo) `CHK(pin_out[p], eq)
        `CHK({lcd_en[p], ana_en[p], xtal_en[p], osc_en[p], cmp_en[p]},
          {k == "L", k == "A", k == "X", k == "O", k == "C"})
        `CHK(per_in.uart_rx, (k == "R") ? lvl : 1'b1)
        `CHK(per_in.sck_i, (k == "k") ? lvl : 1'b0)
        `CHK(per_in.serial_chip_select, (k == "s") ? lvl : 1'b1)
        if (p == 1) `CHK(per_in.external_interrupt_one, !c & lvl)
        if (p == 0) `CHK(per_in.external_interrupt_zero, !c & lvl)
        if (p == 2) `CHK(per_in.standard_timer_clock_input, !c & lvl)
        if (k == "d") `CHK(per_in.serial_data_in_line, lvl)
        // back to gpio before the next function is chosen
        reg_wr(a, `PFS_WORD_ZERO);
      end
    end
  endtask

  // interrupt one taken from b1 or from a2 by the source bit
  task test_external_interrupt_one;
    ext_lvl <= 18'h0_0002;
    pin_a2_in <= 1'b0;
    reg_wr(32'h0000_0014, 32'h0000_0001);
    reg_chk(32'h0000_0014, 32'h0000_0001);
    repeat (3) @(posedge clk);
    `CHK(per_in.external_interrupt_one, 1'b0)
    pin_a2_in <= 1'b1;
    ext_lvl <= 18'h0_0000;
    repeat (3) @(posedge clk);
    `CHK(per_in.external_interrupt_one, 1'b1)
    reg_wr(32'h0000_0014, `PFS_WORD_ZERO);
    repeat (3) @(posedge clk);
    `CHK(per_in.external_interrupt_one, 1'b0)
  endtask

  // main sequence
  initial begin
    hsel = 1'b0;
    haddr = `PFS_WORD_ZERO;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = `PFS_WORD_ZERO;
    pin_a2_in = 1'b0;
    gpio_out = 18'h2_5a5a;
    gpio_oe = 18'h3_c3c0;
    per_out = pfs_periph_out_t'(12'h000);
    ext_lvl = 18'h0_0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_reset();
    test_regs();
    test_routes(pfs_periph_out_t'(12'hab7), 18'h2_a5a5);
    test_routes(pfs_periph_out_t'(12'h548), 18'h1_5a5a);
    test_external_interrupt_one();
    test_done();
  end
endmodule // testbench
